/* usc_pkg.sv */
// Package for the upstream control / device address / endpoint config block.
// Assumes an APB slave with 32-bit data; registers are one byte wide in bits [7:0].
package usc_pkg;
    // Printed register indices (0x1f is not a multiple of four: byte address = 4*index)
    localparam logic [7:0] USC_IDX_ADDR_A     = 8'h10;
    localparam logic [7:0] USC_IDX_STAT_CTRL  = 8'h1f;
    localparam logic [7:0] USC_IDX_ADDR_B     = 8'h40;
    localparam logic [7:0] USC_IDX_EP_CFG     = 8'h50;
    localparam int         USC_PADDR_W        = 12;

    // Status/control field positions
    localparam int USC_SC_ACT_LSB  = 0;
    localparam int USC_SC_ACTIVITY = 3;
    localparam int USC_SC_DMINUS   = 4;
    localparam int USC_SC_DPLUS    = 5;
    localparam int USC_SC_EP_MODE  = 6;
    localparam int USC_SC_EP_SIZE  = 7;
    localparam logic [7:0] USC_SC_RESET   = 8'h00;
    localparam logic [7:0] USC_ADDR_RESET = 8'h00;
    localparam int USC_ADDR_EN     = 7;

    // Control action codes
    localparam logic [2:0] USC_ACT_NONE     = 3'h0;
    localparam logic [2:0] USC_ACT_J        = 3'h1;
    localparam logic [2:0] USC_ACT_K        = 3'h2;
    localparam logic [2:0] USC_ACT_SE0      = 3'h3;
    localparam logic [2:0] USC_ACT_LOW      = 3'h4;
    localparam logic [2:0] USC_ACT_DP_FLOAT = 3'h5;
    localparam logic [2:0] USC_ACT_DM_FLOAT = 3'h6;
    localparam logic [2:0] USC_ACT_FLOAT    = 3'h7;

    // FIFO base addresses in user RAM
    localparam logic [7:0] USC_FIFO_SMALL_BASE = 8'hd8;
    localparam logic [7:0] USC_FIFO_LARGE_BASE = 8'ha8;
    localparam logic [7:0] USC_FIFO_BIG0_BASE  = 8'hc0;
    localparam logic [7:0] USC_FIFO_BIG1_BASE  = 8'he0;
    localparam logic [7:0] USC_FIFO_SMALL_SZ   = 8'h08;
    localparam logic [7:0] USC_FIFO_BIG_SZ     = 8'h20;

    // CPU stall per engine byte write
    localparam int USC_STALL_CYCLES = 3;
    localparam int USC_NUM_EP       = 5;
endpackage

/* usc_stall.sv */
// Stall generator: holds the CPU off the internal data bus during engine FIFO writes.
// Assumes byte write requests come from the engine on the same clock.
`timescale 1ns/10ps
module usc_stall #(
    parameter int CYCLES = usc_pkg::USC_STALL_CYCLES
) (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic resetn_i,
    // Engine byte request
    input  wire logic wr_req_i,
    output logic      wr_ack_o,
    // CPU stall
    output logic      stall_o
);
    logic [3:0] cnt_reg;

    // Each accepted byte owns the bus for CYCLES cycles
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end else if (wr_req_i) begin
            cnt_reg <= 4'(CYCLES - 1);
        end
    end

    // Ack the byte in the first of its stall cycles
    assign wr_ack_o = (cnt_reg == 4'h0) && wr_req_i;
    assign stall_o  = wr_ack_o || (cnt_reg != 4'h0);

    stall_len_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        wr_ack_o |-> stall_o ##1 stall_o ##1 stall_o)
        else $error("stall shorter than three cycles");
endmodule

/* usc_top.sv */
// Upstream port control, device addresses, endpoint config and FIFO stall logic.
// Assumes an APB master on core_clk_i and upstream pins from outside (synchronised here).
`timescale 1ns/10ps

module usc_top (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic             pready_o,
    output logic [31:0]      prdata_o,
    output logic             pslverr_o,
    // Upstream pins
    input  wire logic        dp_i,
    input  wire logic        dm_i,
    output logic             dp_o,
    output logic             dp_oe_o,
    output logic             dm_o,
    output logic             dm_oe_o,
    // Serial engine line drive and events
    input  wire logic        sie_dp_i,
    input  wire logic        sie_dm_i,
    input  wire logic        sie_oe_i,
    input  wire logic        eof1_i,
    input  wire logic        token_valid_i,
    input  wire logic [6:0]  token_addr_i,
    input  wire logic [3:0]  token_ep_i,
    // Engine FIFO byte writes into user RAM
    input  wire logic        fifo_wr_req_i,
    input  wire logic [2:0]  fifo_ep_i,
    input  wire logic [5:0]  fifo_offset_i,
    output logic             fifo_wr_ack_o,
    output logic [7:0]       fifo_ram_addr_o,
    // CPU and engine decode results
    output logic             cpu_stall_o,
    output logic             match_a_o,
    output logic             match_b_o,
    output logic [2:0]       match_ep_o,
    output logic             b0_is_pipe_three_o,
    output logic             eop_req_o
);
    logic [7:0] sc_reg;
    logic [7:0] addr_a_reg;
    logic [7:0] addr_b_reg;
    logic [1:0] dp_sync_reg;
    logic [1:0] dm_sync_reg;
    logic       wr_en;
    logic       rd_en;
    logic       hit;
    logic [9:0] idx;
    logic       activity_evt;
    logic [7:0] ram_addr_next;

    // Register index from byte address; byte lane zero carries data
    assign idx   = paddr_i[11:2];
    assign wr_en = psel_i && penable_i && pwrite_i && pstrb_i[0];
    assign rd_en = psel_i && !pwrite_i;
    assign hit   = (idx == {2'b00, usc_pkg::USC_IDX_ADDR_A})
                || (idx == {2'b00, usc_pkg::USC_IDX_STAT_CTRL})
                || (idx == {2'b00, usc_pkg::USC_IDX_ADDR_B})
                || (idx == {2'b00, usc_pkg::USC_IDX_EP_CFG});

    // Zero wait states; unmapped addresses answer with an error
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit;

    // Pins pass two flops before anything reads them
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            // Reset to J so leaving reset is not taken as bus activity
            dp_sync_reg <= 2'b11;
            dm_sync_reg <= 2'b00;
        end else begin
            dp_sync_reg <= {dp_sync_reg[0], dp_i};
            dm_sync_reg <= {dm_sync_reg[0], dm_i};
        end
    end

    // Non-idle means anything other than J (D+ high, D- low) on the line
    assign activity_evt = !(dp_sync_reg[1] && !dm_sync_reg[1]);

    // Status/control register: config, activity, control action
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sc_reg <= usc_pkg::USC_SC_RESET;
        end else begin
            if (wr_en && idx == {2'b00, usc_pkg::USC_IDX_STAT_CTRL}) begin
                sc_reg[2:0] <= pwdata_i[2:0];
                sc_reg[7:6] <= pwdata_i[7:6];
                if (!pwdata_i[usc_pkg::USC_SC_ACTIVITY]) begin
                    sc_reg[usc_pkg::USC_SC_ACTIVITY] <= 1'b0;
                end
            end
            if (activity_evt) begin
                sc_reg[usc_pkg::USC_SC_ACTIVITY] <= 1'b1;
            end
            sc_reg[5:4] <= 2'b00;
        end
    end

    // Device address registers
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_a_reg <= usc_pkg::USC_ADDR_RESET;
            addr_b_reg <= usc_pkg::USC_ADDR_RESET;
        end else if (wr_en) begin
            if (idx == {2'b00, usc_pkg::USC_IDX_ADDR_A}) begin
                addr_a_reg <= pwdata_i[7:0];
            end
            if (idx == {2'b00, usc_pkg::USC_IDX_ADDR_B}) begin
                addr_b_reg <= pwdata_i[7:0];
            end
        end
    end

    // Read mux; pin levels are live, upper bits read zero
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd_en && !penable_i) begin
            prdata_o <= 32'h0000_0000;
            if (idx == {2'b00, usc_pkg::USC_IDX_STAT_CTRL}) begin
                prdata_o[7:0] <= {sc_reg[7:6], dp_sync_reg[1], dm_sync_reg[1], sc_reg[3:0]};
            end else if (idx == {2'b00, usc_pkg::USC_IDX_ADDR_A}) begin
                prdata_o[7:0] <= addr_a_reg;
            end else if (idx == {2'b00, usc_pkg::USC_IDX_ADDR_B}) begin
                prdata_o[7:0] <= addr_b_reg;
            end else if (idx == {2'b00, usc_pkg::USC_IDX_EP_CFG}) begin
                // fixed capability: 2 addresses, 5 endpoints
                prdata_o[7:0] <= 8'h25;
            end
        end
    end

    // Upstream drivers: engine or firmware override
    always_comb begin
        dp_o    = 1'b0;
        dm_o    = 1'b0;
        dp_oe_o = 1'b1;
        dm_oe_o = 1'b1;
        case (sc_reg[2:0])
            usc_pkg::USC_ACT_NONE: begin
                dp_o    = sie_dp_i;
                dm_o    = sie_dm_i;
                dp_oe_o = sie_oe_i;
                dm_oe_o = sie_oe_i;
            end
            usc_pkg::USC_ACT_J: begin
                dp_o = 1'b1;
            end
            usc_pkg::USC_ACT_K: begin
                dm_o = 1'b1;
            end
            usc_pkg::USC_ACT_SE0: begin
                dp_o = 1'b0;
            end
            usc_pkg::USC_ACT_LOW: begin
                dm_o = 1'b0;
            end
            usc_pkg::USC_ACT_DP_FLOAT: begin
                dp_oe_o = 1'b0;
            end
            usc_pkg::USC_ACT_DM_FLOAT: begin
                dm_oe_o = 1'b0;
            end
            usc_pkg::USC_ACT_FLOAT: begin
                dp_oe_o = 1'b0;
                dm_oe_o = 1'b0;
            end
            default: begin
                dp_oe_o = 1'b0;
                dm_oe_o = 1'b0;
            end
        endcase
    end

    // EOP request at EOF1, only when engine owns the line
    assign eop_req_o = eof1_i && (sc_reg[2:0] == usc_pkg::USC_ACT_NONE);

    // second control register remapped in five-endpoint mode
    assign b0_is_pipe_three_o = sc_reg[usc_pkg::USC_SC_EP_MODE];

    // Address match; one-address mode turns B off entirely
    always_comb begin
        match_a_o  = 1'b0;
        match_b_o  = 1'b0;
        match_ep_o = 3'h0;
        if (token_valid_i) begin
            if (addr_a_reg[usc_pkg::USC_ADDR_EN] && token_addr_i == addr_a_reg[6:0]) begin
                // A owns 0..2, or 0..4 with one address
                if (token_ep_i < (sc_reg[usc_pkg::USC_SC_EP_MODE] ? 4'h5 : 4'h3)) begin
                    match_a_o  = 1'b1;
                    match_ep_o = token_ep_i[2:0];
                end
            end else if (!sc_reg[usc_pkg::USC_SC_EP_MODE]
                         && addr_b_reg[usc_pkg::USC_ADDR_EN]
                         && token_addr_i == addr_b_reg[6:0] && token_ep_i < 4'h2) begin
                match_b_o  = 1'b1;
                match_ep_o = 3'(token_ep_i + 4'h3);
            end
        end
    end

    // Flat endpoint index 0..4 -> FIFO base in user RAM
    function automatic logic [7:0] fifo_base(input logic size, input logic [2:0] ep);
        logic [7:0] base;
        base = 8'h00;
        if (!size) begin
            // five 8-byte FIFOs from top down
            base = 8'hf8 - {2'b00, ep, 3'b000};
        end else begin
            case (ep)
                3'h0:    base = usc_pkg::USC_FIFO_LARGE_BASE + 8'h10;
                3'h1:    base = usc_pkg::USC_FIFO_BIG0_BASE;
                3'h2:    base = usc_pkg::USC_FIFO_BIG1_BASE;
                3'h3:    base = usc_pkg::USC_FIFO_LARGE_BASE;
                3'h4:    base = usc_pkg::USC_FIFO_LARGE_BASE + 8'h08;
                default: base = 8'h00;
            endcase
        end
        return base;
    endfunction

    // Offset limited to FIFO size so writes stay inside their own slot
    always_comb begin
        logic [7:0] lim;
        lim = usc_pkg::USC_FIFO_SMALL_SZ;
        if (sc_reg[usc_pkg::USC_SC_EP_SIZE] && (fifo_ep_i == 3'h1 || fifo_ep_i == 3'h2)) begin
            lim = usc_pkg::USC_FIFO_BIG_SZ;
        end
        ram_addr_next = fifo_base(sc_reg[usc_pkg::USC_SC_EP_SIZE], fifo_ep_i)
                      + ({2'b00, fifo_offset_i} & (lim - 8'h01));
    end

    // Registered RAM address for the accepted byte
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fifo_ram_addr_o <= 8'h00;
        end else if (fifo_wr_ack_o) begin
            fifo_ram_addr_o <= ram_addr_next;
        end
    end

    usc_stall #(
        .CYCLES (usc_pkg::USC_STALL_CYCLES)
    ) u_stall (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .wr_req_i   (fifo_wr_req_i),
        .wr_ack_o   (fifo_wr_ack_o),
        .stall_o    (cpu_stall_o)
    );

    // Assertions
    forced_j_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        sc_reg[2:0] == 3'h1 |-> dp_o && !dm_o && dp_oe_o && dm_oe_o)
        else $error("code 1 does not force J");
    float_both_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        sc_reg[2:0] == 3'h7 |-> !dp_oe_o && !dm_oe_o)
        else $error("code 7 does not float");
    float_dp_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        sc_reg[2:0] == 3'h5 |-> !dp_oe_o && dm_oe_o && !dm_o)
        else $error("code 5 wrong");
    sie_pass_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        sc_reg[2:0] == 3'h0 |-> dp_o == sie_dp_i && dp_oe_o == sie_oe_i)
        else $error("engine not in control");
    act_set_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        activity_evt |=> sc_reg[3])
        else $error("activity not set");
    act_keep_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        sc_reg[3] && !(wr_en && idx == 10'h01f && !pwdata_i[3]) |=> sc_reg[3])
        else $error("activity lost");
    pin_read_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        rd_en && !penable_i && idx == 10'h01f |=> prdata_o[5] == $past(dp_sync_reg[1]))
        else $error("pin level misread");
    addr_en_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        match_a_o |-> addr_a_reg[7] && token_addr_i == addr_a_reg[6:0])
        else $error("match without enable");
    one_addr_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        sc_reg[6] |-> !match_b_o)
        else $error("second address in one-address mode");
    forced_k_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        sc_reg[2:0] == 3'h2 |-> !dp_o && dm_o && dp_oe_o && dm_oe_o)
        else $error("code 2 does not force K");
    both_low_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (sc_reg[2:0] == 3'h3 || sc_reg[2:0] == 3'h4) |-> !dp_o && !dm_o && dp_oe_o && dm_oe_o)
        else $error("codes 3 and 4 do not drive both low");
    float_dm_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        sc_reg[2:0] == 3'h6 |-> dp_oe_o && !dp_o && !dm_oe_o)
        else $error("code 6 wrong");
    act_clear_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        wr_en && idx == 10'h01f && !pwdata_i[3] && !activity_evt |=> !sc_reg[3])
        else $error("activity not cleared");
    pin_dm_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        rd_en && !penable_i && idx == 10'h01f |=> prdata_o[4] == $past(dm_sync_reg[1]))
        else $error("D- level misread");
    cv_force_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i) sc_reg[2:0] == 3'h3);
    cv_clear_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i) $fell(sc_reg[3]));
    cv_match_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i) match_b_o);
    cv_stall_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i) cpu_stall_o[*4]);
endmodule

/* usc_host_model.sv */
// Upstream host model: resolves the D+/D- wires between host and device.
// Assumes the bench commands host drive; an enabled device driver wins.
`timescale 1ns/10ps
module usc_host_model (
    // Device drive
    input  wire logic dp_i,
    input  wire logic dp_oe_i,
    input  wire logic dm_i,
    input  wire logic dm_oe_i,
    // Host commands
    input  wire logic host_en_i,
    input  wire logic host_dp_i,
    input  wire logic host_dm_i,
    // Resolved wire levels
    output logic      dp_line_o,
    output logic      dm_line_o
);
    // Pull-up on D+ and pull-down on D- give J when nobody drives
    always_comb begin
        dp_line_o = dp_oe_i ? dp_i : (host_en_i ? host_dp_i : 1'b1);
        dm_line_o = dm_oe_i ? dm_i : (host_en_i ? host_dm_i : 1'b0);
    end
endmodule

/* usc_top_tb.sv */
// Self-checking bench for usc_top: APB master, host line model, engine stimulus.
// Assumes pready combinational, prdata latched at setup, 2-flop pin synchroniser.
`timescale 1ns/10ps
module usc_top_tb;
    localparam logic [11:0] A_AD  = 12'h040;
    localparam logic [11:0] SC_AD = 12'h07c;
    localparam logic [11:0] B_AD  = 12'h100;
    logic        core_clk_i, resetn_i, psel, penable, pwrite, pready, pslverr, se;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        dp_o, dp_oe, dm_o, dm_oe, dpl, dml, h_en, h_dp, h_dm;
    logic        sdp, sdm, soe, eof1, tv, f_req, f_ack, stall, ma, mb, b0p3, eop;
    logic [6:0]  ta, ra;
    logic [3:0]  te, ex;
    logic [2:0]  f_ep, mep;
    logic [5:0]  f_off;
    logic [7:0]  f_addr;
    int          error_cnt, n_checks, seed, w;

    usc_top dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(4'hf), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
        .dp_i(dpl), .dm_i(dml), .dp_o(dp_o), .dp_oe_o(dp_oe), .dm_o(dm_o),
        .dm_oe_o(dm_oe), .sie_dp_i(sdp), .sie_dm_i(sdm), .sie_oe_i(soe),
        .eof1_i(eof1), .token_valid_i(tv), .token_addr_i(ta), .token_ep_i(te),
        .fifo_wr_req_i(f_req), .fifo_ep_i(f_ep), .fifo_offset_i(f_off),
        .fifo_wr_ack_o(f_ack), .fifo_ram_addr_o(f_addr), .cpu_stall_o(stall),
        .match_a_o(ma), .match_b_o(mb), .match_ep_o(mep),
        .b0_is_pipe_three_o(b0p3), .eop_req_o(eop));
    usc_host_model host (.dp_i(dp_o), .dp_oe_i(dp_oe), .dm_i(dm_o), .dm_oe_i(dm_oe),
        .host_en_i(h_en), .host_dp_i(h_dp), .host_dm_i(h_dm),
        .dp_line_o(dpl), .dm_line_o(dml));

    // Free-running 200 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask

    // One APB transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge core_clk_i);
        penable <= 1'b1;
        // Ends at the first edge with pready high; only the watchdog ends a hang
        do begin
            @(posedge core_clk_i);
        end while (pready !== 1'b1);
        r  = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Expected {D+ wire, D+ oe, D- wire, D- oe} for an action code
    function automatic logic [3:0] drv_exp(input logic [2:0] c);
        case (c)
            3'd0:    return {soe ? sdp : 1'b1, soe, soe ? sdm : 1'b0, soe};
            3'd1:    return 4'b1101;
            3'd2:    return 4'b0111;
            3'd5:    return 4'b1001;
            3'd6:    return 4'b0100;
            3'd7:    return 4'b1000;
            default: return 4'b0101;
        endcase
    endfunction

    // Expected user-RAM address: base per endpoint, offset wraps in FIFO size
    function automatic logic [7:0] fifo_exp(input logic sz, input logic [2:0] ep,
                                            input logic [5:0] off);
        logic [7:0] b;
        logic [7:0] m;
        b = 8'hf8 - {2'b00, ep, 3'b000};
        if (sz)
            b = (ep == 0) ? 8'hb8 : (ep == 1) ? 8'hc0 : (ep == 2) ? 8'he0 :
                (ep == 3) ? 8'ha8 : 8'hb0;
        m = (sz && (ep == 1 || ep == 2)) ? 8'h1f : 8'h07;
        return b + ({2'b00, off} & m);
    endfunction

    // Engine byte write; request left high, returns one edge after the accept
    // so the next byte is driven on a rising edge
    task automatic fbyte(input logic sz, input logic [2:0] ep, input logic [5:0] off);
        w = 0;
        f_ep  <= ep;
        f_off <= off;
        f_req <= 1'b1;
        do begin
            @(posedge core_clk_i);
            w++;
        end while (f_ack !== 1'b1 && w < 20);
        #1;
        chk(f_addr, fifo_exp(sz, ep, off));
        chk(stall, 1'b1);
        @(posedge core_clk_i);
    endtask

    // Register values after a reset; idle line reads D+ high and no activity
    task automatic rst_chk();
        apb(1'b0, A_AD, 8'h0);
        chk(r, 32'h0);
        apb(1'b0, B_AD, 8'h0);
        chk(r, 32'h0);
        apb(1'b0, SC_AD, 8'h0);
        chk(r, 32'h20);
    endtask

    // Watchdog sized well above the expected run length
    initial begin
        #(40000 * 5);
        error_cnt++;
        end_sim();
    end

    initial begin
        seed = 32'h8621;
        {resetn_i, psel, penable, pwrite, paddr, pwdata} = '0;
        {h_en, h_dp, h_dm, sdp, sdm, soe, eof1, tv, ta, te} = '0;
        {f_req, f_ep, f_off} = '0;
        repeat (6) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        rst_chk();
        apb(1'b0, 12'h140, 8'h0);
        chk(r, 32'h25);
        apb(1'b0, 12'h008, 8'h0);
        chk(se, 1'b1);
        chk(r, 32'h0);
        // Every action code; pin bits must follow the wire while forced
        for (int c = 0; c < 8; c++) begin
            {sdp, sdm, soe} <= 3'($random(seed));
            apb(1'b1, SC_AD, {5'b00111, 3'(c)}); // manual codes on purpose
            repeat (3) @(posedge core_clk_i);
            ex = drv_exp(3'(c));
            chk({dpl, dp_oe, dml, dm_oe}, ex);
            apb(1'b0, SC_AD, 8'h0);
            chk(r & 32'hf7, {2'b00, ex[3], ex[1], 1'b0, 3'(c)});
        end
        soe <= 1'b0;
        apb(1'b1, SC_AD, 8'h00); // normal signalling
        repeat (4) @(posedge core_clk_i);
        apb(1'b1, SC_AD, 8'h00);
        apb(1'b0, SC_AD, 8'h0);
        chk(r, 32'h20);
        // Host K burst sets the sticky flag; write 1 keeps, write 0 clears
        h_en <= 1'b1;
        h_dm <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        h_en <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        apb(1'b1, SC_AD, 8'h38);
        apb(1'b0, SC_AD, 8'h0);
        chk(r, 32'h28);
        apb(1'b1, SC_AD, 8'h30);
        apb(1'b0, SC_AD, 8'h0);
        chk(r, 32'h20);
        // End of packet follows frame point only when not forcing
        eof1 <= 1'b1;
        #1;
        chk(eop, 1'b1);
        @(posedge core_clk_i);
        eof1 <= 1'b0;
        // Address match only with enable set
        ra = 7'($random(seed)) | 7'h01;
        apb(1'b1, A_AD, {1'b1, ra}); // firmware enumeration
        apb(1'b1, B_AD, {1'b1, ra ^ 7'h40});
        apb(1'b0, A_AD, 8'h0);
        chk(r, {24'h0, 1'b1, ra});
        tv <= 1'b1;
        ta <= ra;
        te <= 4'd2;
        #1;
        chk({ma, mb, mep}, 5'b10010);
        @(posedge core_clk_i);
        ta <= ra ^ 7'h40;
        te <= 4'd1;
        #1;
        chk({ma, mb, mep}, 5'b01100);
        apb(1'b1, B_AD, {1'b0, ra ^ 7'h40});
        #1;
        chk({ma, mb}, 2'b00);
        // One-address mode: second control register becomes pipe three
        apb(1'b1, SC_AD, 8'h40);
        ta <= ra;
        te <= 4'd4;
        #1;
        chk({b0p3, ma, mep}, 5'b11100);
        @(posedge core_clk_i);
        tv <= 1'b0;
        // FIFO layout for both sizes, bytes back to back
        for (int sz = 0; sz < 2; sz++) begin
            apb(1'b1, SC_AD, {1'(sz), 7'h0});
            for (int e = 0; e < 5; e++) begin
                fbyte(1'(sz), 3'(e), 6'($random(seed)));
                chk(w, (e == 0) ? 1 : usc_pkg::USC_STALL_CYCLES - 1);
            end
            f_req <= 1'b0;
            #1;
            chk(stall, 1'b1);
            @(posedge core_clk_i);
            #1;
            chk(stall, 1'b0);
        end
        // Reset in mid-run clears everything again
        @(posedge core_clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        rst_chk();
        chk(b0p3, 1'b0);
        end_sim();
    end
endmodule
